// >>> core/sensor_frontend_ctrl.sv
// external sensor front-end control with apb configuration port
// Operation
// - type a 11 drives ac stimulus on excitation during point a or b conversion, not temperature
// - ac stimulus is square wave around reference, amplitude of reference
// - type a 00 means linear resistive, dc bias, no ac
// - bridge mode with type b 1 and b enabled converts point a then point b in sequence
// - type b 0 means conductive, diode or current source sensor
// - type b 1 means high impedance voltage source input
// - spi or radio configuration both act identically
// - front end autoranges or uses preset fixed gain
// - gain a from 5-bit current preset, b from ladder preset
// - presets apply only with preset flag, which disables autorange
// - only the selected sensor is compared in out-of-limits mode
// - supply switch and 2-bit irq level come from calibration data
// - with switch on, battery on excitation only during conversion
// - irq-plus-timer flag runs timed and interrupt logging together
// - type a 00: battery only if switch on and not standby
// - temperature and external inputs convert strictly one at a time
// - limit select picks first to third enabled sensor, fourth setting picks none
`timescale 1ns/1ns
module sensor_frontend_ctrl
    import frontend_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog front-end controls
    output logic [4:0] gain_a,
    output logic [4:0] gain_b,
    output logic autorange_en,
    output logic [1:0] irq_level,
    output logic [1:0] mux_sel,
    output logic conv_active,
    output logic limit_sensor_valid,
    output logic [1:0] limit_channel,
    output logic irq_timer_mode,
    // excitation pin: level (1 vbat / ac high) and enable
    output logic excite_out,
    output logic excite_oe,
    output logic excite_is_ac,
    output logic sensor_b_high_z
);
    // stored configuration, one copy for both configuration paths
    logic [15:0] frontend;
    logic [2:0] calib;
    logic [4:0] logging;
    logic [15:0] next_frontend;
    logic [2:0] next_calib;
    logic [4:0] next_logging;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic next_pready;
    // conversion sequencer state
    conv_state_t state;
    conv_state_t next_state;
    logic [7:0] timer;
    logic [7:0] next_timer;
    logic [1:0] chan;
    logic [1:0] next_chan;
    logic [2:0] ac_cnt;
    logic [2:0] next_ac_cnt;
    logic ac_phase;
    logic next_ac_phase;
    // registered outputs' next values
    logic next_exc_out;
    logic next_exc_oe;
    logic next_is_ac;
    logic [1:0] next_lim_ch;
    logic next_lim_ok;
    logic setup_ph;
    logic wr_conv;
    logic wr_done;
    logic [1:0] req_chan;
    logic [1:0] type_a;
    logic standby;
    logic sw_on;
    assign setup_ph = psel && !penable;
    // a write counts only at the edge where the access phase completes
    assign wr_done = psel && penable && pready && pwrite;
    assign wr_conv = wr_done && paddr == OFS_CONVERT && pwdata[START_BIT];
    assign req_chan = pwdata[CHAN_LSB +: 2];
    assign type_a = frontend[TYPE_A_LSB +: 2];
    assign standby = logging[STANDBY_BIT];
    assign sw_on = calib[SWITCH_BIT];

    // index of the n-th enabled sensor, order temp, a, b
    function automatic logic [2:0] pick_enabled(input logic [1:0] n,
                                                input logic [2:0] en);
        logic [1:0] seen;
        logic [2:0] res;
        seen = 2'h0;
        res = 3'h0;
        for (int i = 0; i < 3; i++) begin
            if (en[i] && !res[2]) begin
                if (seen == n) begin
                    res = {1'b1, 2'(i)};
                end
                seen = seen + 2'h1;
            end
        end
        return res;
    endfunction

    // apb slave: answers in the access phase, zero wait states
    always_comb begin
        next_frontend = frontend;
        next_calib = calib;
        next_logging = logging;
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        next_pready = setup_ph;
        if (setup_ph) begin
            unique case (paddr)
                OFS_FRONTEND: next_prdata = {16'h0000, frontend};
                OFS_CALIB: next_prdata = {29'h0, calib};
                OFS_LOGGING: next_prdata = {27'h0, logging};
                OFS_CONVERT: next_prdata = 32'h0000_0000;
                OFS_STATUS: next_prdata = {27'h0, chan, state, conv_active};
                default: next_pslverr = 1'b1;
            endcase
            if (pwrite && paddr == OFS_STATUS) next_pslverr = 1'b1;
        end
        // writes land when the transfer completes, never in setup
        if (wr_done) begin
            unique case (paddr)
                OFS_FRONTEND: next_frontend = pwdata[15:0];
                OFS_CALIB: next_calib = pwdata[2:0];
                OFS_LOGGING: next_logging = pwdata[4:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            frontend <= FRONTEND_RESET;
            calib <= CALIB_RESET;
            logging <= LOGGING_RESET;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            frontend <= next_frontend;
            calib <= next_calib;
            logging <= next_logging;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
            pready <= next_pready;
        end
    end

    // conversion sequencer; one channel through the single converter
    always_comb begin
        next_state = state;
        next_timer = timer;
        next_chan = chan;
        unique case (state)
            ST_IDLE: begin
                if (wr_conv && req_chan != 2'h3
                    && logging[req_chan]) begin
                    next_chan = req_chan;
                    next_timer = 8'(CONV_CYCLES - 1);
                    next_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (timer != 8'h00) begin
                    next_timer = timer - 8'h01;
                end else if (chan == CH_A && type_a == TYPE_A_BRIDGE
                    && frontend[TYPE_B_BIT] && logging[EN_B_BIT]) begin
                    next_state = ST_NEXT;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            ST_NEXT: begin
                next_chan = CH_B;
                next_timer = 8'(CONV_CYCLES - 1);
                next_state = ST_CONV;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // excitation pin control and ac square wave
    always_comb begin
        next_ac_cnt = 3'h0;
        next_ac_phase = 1'b0;
        next_exc_out = 1'b0;
        next_exc_oe = 1'b0;
        next_is_ac = 1'b0;
        if (next_state == ST_CONV && next_chan != CH_TEMP) begin
            if (type_a == TYPE_A_AC) begin
                // square wave, analog level set by reference
                next_ac_cnt = ac_cnt + 3'h1;
                next_ac_phase = ac_phase;
                if (ac_cnt == 3'(AC_HALF_CYCLES - 1)) begin
                    next_ac_cnt = 3'h0;
                    next_ac_phase = !ac_phase;
                end
                next_exc_out = next_ac_phase;
                next_exc_oe = 1'b1;
                next_is_ac = 1'b1;
            end else if (type_a != TYPE_A_RESERVED && sw_on
                && !standby) begin
                // dc bias only, no ac for linear
                next_exc_out = 1'b1;
                next_exc_oe = 1'b1;
            end
        end
    end

    always_comb begin
        {next_lim_ok, next_lim_ch} =
            pick_enabled(frontend[LIMSEL_LSB +: 2], logging[2:0]);
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state <= ST_IDLE;
            timer <= 8'h00;
            chan <= CH_TEMP;
            ac_cnt <= 3'h0;
            ac_phase <= 1'b0;
            excite_out <= 1'b0;
            excite_oe <= 1'b0;
            excite_is_ac <= 1'b0;
            conv_active <= 1'b0;
            mux_sel <= CH_TEMP;
            limit_channel <= 2'h0;
            limit_sensor_valid <= 1'b0;
            gain_a <= 5'h00;
            gain_b <= 5'h00;
            autorange_en <= 1'b1;
            irq_level <= 2'h0;
            irq_timer_mode <= 1'b0;
            sensor_b_high_z <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            chan <= next_chan;
            ac_cnt <= next_ac_cnt;
            ac_phase <= next_ac_phase;
            excite_out <= next_exc_out;
            excite_oe <= next_exc_oe;
            excite_is_ac <= next_is_ac;
            conv_active <= next_state == ST_CONV;
            mux_sel <= next_chan;
            limit_channel <= next_lim_ch;
            limit_sensor_valid <= next_lim_ok;
            // gain a seti, gain b ladder
            gain_a <= frontend[PRESET_BIT] ? frontend[SETI_LSB +: 5] : 5'h00;
            gain_b <= frontend[PRESET_BIT] ? frontend[RANG_LSB +: 5] : 5'h00;
            autorange_en <= !frontend[PRESET_BIT];
            irq_level <= calib[IRLEV_LSB +: 2];
            irq_timer_mode <= logging[IRQ_TIMER_BIT];
            // type b 0 low impedance sensor
            sensor_b_high_z <= frontend[TYPE_B_BIT];
        end
    end

    // every check runs on ref_clk and sleeps while reset is high
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    // bridge: b conversion starts the cycle after the one ST_NEXT cycle that follows a
    chk_bridge_sequence: assert property (
        state == ST_NEXT |=> state == ST_CONV && chan == CH_B)
        else $error("bridge second point not converted");
    // pin flops lag the settings by a cycle, so compare the old settings
    chk_ac_only_conv: assert property (
        excite_is_ac |-> conv_active && $past(type_a) == TYPE_A_AC)
        else $error("ac stimulus outside ac conversion");
    chk_vbat_gated: assert property (
        excite_oe && !excite_is_ac |-> $past(sw_on) && !$past(standby)
        && conv_active)
        else $error("battery on excitation without permission");
    chk_linear_no_ac: assert property (
        $past(type_a) == TYPE_A_LINEAR && type_a == TYPE_A_LINEAR
        |-> !excite_is_ac)
        else $error("ac stimulus on linear sensor");
    chk_reserved_hiz: assert property (
        $past(type_a) == TYPE_A_RESERVED && type_a == TYPE_A_RESERVED
        |-> !excite_oe)
        else $error("excitation driven for reserved type");
    chk_release_after: assert property (
        $fell(conv_active) |-> !excite_oe)
        else $error("excitation held after conversion");
    chk_square_wave: assert property (
        excite_is_ac && $past(excite_is_ac) && $changed(excite_out)
        |=> $stable(excite_out)[*3] or !excite_is_ac)
        else $error("ac half period too short");
    chk_preset_gain: assert property (
        frontend[PRESET_BIT] |=> !autorange_en)
        else $error("autorange while preset set");
    chk_one_at_time: assert property (
        state == ST_CONV && timer != 8'h00 |=> $stable(chan))
        else $error("channel changed mid conversion");
    chk_gain_a: assert property (
        frontend[PRESET_BIT] |=> gain_a == $past(frontend[SETI_LSB +: 5]))
        else $error("gain a not from preset");
endmodule

// >>> include/frontend_pkg.sv
// constants for the external sensor front-end control block
package frontend_pkg;
    // apb register byte offsets
    localparam logic [7:0] OFS_FRONTEND = 8'h00;
    localparam logic [7:0] OFS_CALIB = 8'h04;
    localparam logic [7:0] OFS_LOGGING = 8'h08;
    localparam logic [7:0] OFS_CONVERT = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    // frontend register fields
    localparam int SETI_LSB = 0;
    localparam int RANG_LSB = 5;
    localparam int TYPE_A_LSB = 10;
    localparam int TYPE_B_BIT = 12;
    localparam int PRESET_BIT = 13;
    localparam int LIMSEL_LSB = 14;
    // calibration register fields
    localparam int SWITCH_BIT = 0;
    localparam int IRLEV_LSB = 1;
    // logging register fields
    localparam int EN_TEMP_BIT = 0;
    localparam int EN_A_BIT = 1;
    localparam int EN_B_BIT = 2;
    localparam int IRQ_TIMER_BIT = 3;
    localparam int STANDBY_BIT = 4;
    // convert register fields: start pulse and channel
    localparam int START_BIT = 0;
    localparam int CHAN_LSB = 1;
    // sensor a type codes
    localparam logic [1:0] TYPE_A_LINEAR = 2'h0;
    localparam logic [1:0] TYPE_A_BRIDGE = 2'h1;
    localparam logic [1:0] TYPE_A_RESERVED = 2'h2;
    localparam logic [1:0] TYPE_A_AC = 2'h3;
    // conversion channels
    localparam logic [1:0] CH_TEMP = 2'h0;
    localparam logic [1:0] CH_A = 2'h1;
    localparam logic [1:0] CH_B = 2'h2;
    // timing
    localparam int CLK_MHZ = 10;
    localparam int CONV_TIME_US = 10;
    localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;
    localparam int AC_HALF_CYCLES = 4;
    // reset values
    localparam logic [15:0] FRONTEND_RESET = 16'h0000;
    localparam logic [2:0] CALIB_RESET = 3'h0;
    localparam logic [4:0] LOGGING_RESET = 5'h00;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_NEXT = 2'b10
    } conv_state_t;
endpackage

// >>> test/sensor_pair_model.sv
// behavioural model of the two external sensors on the excitation pin
`timescale 1ns/1ns
module sensor_pair_model (
    // clock and bench control
    input wire logic ref_clk,
    input wire logic clear,
    // excitation pin and conversion window
    input wire logic excite_out,
    input wire logic excite_oe,
    input wire logic conv_active,
    // what the sensors saw during the last conversion
    output int drive_n,
    output int edge_n
);
    logic last = 1'b0;
    logic last_oe;
    logic pin;
    // a released pin floats: show the inverse so a stale level never passes
    assign pin = excite_oe ? excite_out : ~last;
    // count driven cycles and stimulus edges
    always @(posedge ref_clk) begin
        last <= pin;
        last_oe <= excite_oe;
        if (clear) begin
            drive_n <= 0;
            edge_n <= 0;
        end else if (conv_active === 1'b1 && excite_oe === 1'b1) begin
            drive_n <= drive_n + 1;
            if (last_oe === 1'b1 && pin !== last)
                edge_n <= edge_n + 1;
        end
    end
endmodule

// >>> test/tb_external_sensor_frontend_control.sv
// self-checking bench for the sensor front-end control block
`timescale 1ns/1ns
module tb_external_sensor_frontend_control;
    import frontend_pkg::*;
    logic ref_clk, reset, psel, penable, pwrite, clear;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic pready, pslverr, autorange_en, conv_active, limit_sensor_valid;
    logic irq_timer_mode, excite_out, excite_oe, excite_is_ac, sensor_b_high_z;
    logic [4:0] gain_a, gain_b;
    logic [1:0] irq_level, mux_sel, limit_channel, first_mux, want_ch;
    logic [7:0] tbl [6];
    logic [32:0] exp_q [$];
    logic [32:0] mask_q [$];
    logic [32:0] m_now, w_now;
    int fail_count, tests_run, cycles, seed, act_n, b_n, drive_n, edge_n, k;
    int half, ac_n;

    sensor_frontend_ctrl dut (.ref_clk(ref_clk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gain_a(gain_a), .gain_b(gain_b),
        .autorange_en(autorange_en), .irq_level(irq_level),
        .mux_sel(mux_sel), .conv_active(conv_active),
        .limit_sensor_valid(limit_sensor_valid),
        .limit_channel(limit_channel), .irq_timer_mode(irq_timer_mode),
        .excite_out(excite_out), .excite_oe(excite_oe),
        .excite_is_ac(excite_is_ac), .sensor_b_high_z(sensor_b_high_z));
    sensor_pair_model sensors (.ref_clk(ref_clk), .clear(clear),
        .excite_out(excite_out), .excite_oe(excite_oe),
        .conv_active(conv_active), .drive_n(drive_n), .edge_n(edge_n));

    // free-running 10 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic check(string what, logic [32:0] seen, logic [32:0] want);
        tests_run++;
        if (seen !== want) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // apb master: hold the request until pready is sampled high
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d,
                       logic [32:0] want, logic [32:0] m);
        exp_q.push_back(want);
        mask_q.push_back(m);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
        // one more edge so outputs registered from a new setting have settled
        @(posedge ref_clk);
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d, logic err);
        apb(1'b1, a, d, {err, 32'h0}, 33'h1_0000_0000);
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] want);
        apb(1'b0, a, 32'h0, {1'b0, want}, 33'h1_ffff_ffff);
    endtask

    // clear the tallies, start a conversion, wait until quiet
    task automatic conv(logic [1:0] ch, logic twice);
        int q;
        int n;
        clear <= 1'b1;
        @(posedge ref_clk);
        clear <= 1'b0;
        wr(OFS_CONVERT, {29'h0, ch, 1'b1}, 1'b0);
        if (twice)
            wr(OFS_CONVERT, {29'h0, CH_B, 1'b1}, 1'b0);
        q = 0;
        for (n = 0; n < 400 && q < 4; n++) begin
            @(posedge ref_clk);
            q = (conv_active === 1'b0) ? q + 1 : 0;
        end
    endtask

    // answer monitor: oldest note against each completed transfer
    always @(posedge ref_clk) begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
            m_now = mask_q.pop_front();
            w_now = exp_q.pop_front() & m_now;
            check("apb answer", {pslverr, prdata} & m_now, w_now);
        end
    end

    // conversion tallies and run limit
    always @(posedge ref_clk) begin
        cycles++;
        if (clear) begin
            act_n <= 0;
            b_n <= 0;
            ac_n <= 0;
        end else if (conv_active === 1'b1) begin
            act_n <= act_n + 1;
            if (excite_is_ac === 1'b1)
                ac_n <= ac_n + 1;
            if (act_n == 0)
                first_mux <= mux_sel;
            if (mux_sel === CH_B)
                b_n <= b_n + 1;
        end
        if (cycles == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial begin
        seed = 32'h898b;
        {psel, penable, pwrite, clear, paddr, pwdata} = '0;
        reset = 1'b1;
        half = CONV_CYCLES / AC_HALF_CYCLES;
        // type, switch, standby, channel, drives, ac
        tbl = '{8'b00_1_0_01_1_0, 8'b00_1_1_01_0_0, 8'b00_0_0_01_0_0,
                8'b11_0_1_01_1_1, 8'b10_1_0_01_0_0, 8'b00_1_0_00_0_0};
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        rd(OFS_FRONTEND, 32'h0);
        rd(OFS_CALIB, 32'h0);
        rd(OFS_LOGGING, 32'h0);
        rd(OFS_STATUS, 32'h0);
        check("autorange", autorange_en, 1);
        apb(1'b0, 8'h14, 32'h0, 33'h1_0000_0000, 33'h1_0000_0000);
        wr(OFS_STATUS, 32'h1, 1'b1);
        $display("test reset and refusals done");
        // preset gains on and off with random fields
        for (k = 0; k < 4; k++) begin
            v = $random(seed);
            wr(OFS_FRONTEND, {18'h0, k[0], v[12], 2'h0, v[9:0]}, 1'b0);
            check("gain a", gain_a, k[0] ? v[4:0] : 5'h0);
            check("gain b", gain_b, k[0] ? v[9:5] : 5'h0);
            check("autorange", autorange_en, !k[0]);
            check("b high z", sensor_b_high_z, v[12]);
        end
        v = $random(seed);
        wr(OFS_CALIB, {29'h0, v[2:1], 1'b1}, 1'b0);
        check("irq level", irq_level, v[2:1]);
        wr(OFS_LOGGING, {28'h0, v[3], 3'b111}, 1'b0);
        check("irq timer", irq_timer_mode, v[3]);
        $display("test settings done");
        // excitation pin across type, switch and standby
        for (k = 0; k < 6; k++) begin
            wr(OFS_FRONTEND, {20'h0, tbl[k][7:6], 10'h0}, 1'b0);
            wr(OFS_CALIB, {31'h0, tbl[k][5]}, 1'b0);
            wr(OFS_LOGGING, {27'h0, tbl[k][4], 4'b0111}, 1'b0);
            conv(tbl[k][3:2], 1'b0);
            check("conv length", act_n, CONV_CYCLES);
            check("drive", drive_n, tbl[k][1] ? CONV_CYCLES : 0);
            check("ac edges", edge_n, tbl[k][0] ? half : 0);
            check("ac flag", ac_n, tbl[k][0] ? CONV_CYCLES : 0);
            check("released", excite_oe, 0);
        end
        $display("test excitation done");
        // bridge with both points enabled, then start while busy
        wr(OFS_FRONTEND, {19'h0, 1'b1, TYPE_A_BRIDGE, 10'h0}, 1'b0);
        conv(CH_A, 1'b0);
        check("bridge total", act_n, 2 * CONV_CYCLES);
        check("bridge b", b_n, CONV_CYCLES);
        check("bridge first", first_mux, CH_A);
        // second single read of the bridge: point b alone, no chaining
        conv(CH_B, 1'b0);
        check("bridge read b", b_n, CONV_CYCLES);
        check("bridge read b only", act_n, CONV_CYCLES);
        wr(OFS_FRONTEND, 32'h0, 1'b0);
        conv(CH_A, 1'b1);
        check("busy start", act_n + b_n, CONV_CYCLES);
        rd(OFS_STATUS, {27'h0, CH_A, 3'h0});
        wr(OFS_LOGGING, 32'h1, 1'b0);
        conv(CH_A, 1'b0);
        check("disabled", act_n, 0);
        $display("test sequencing done");
        // limit sensor select over random enable sets, preset range on
        for (k = 0; k < 4; k++) begin
            v = $random(seed);
            wr(OFS_LOGGING, {29'h0, v[2:0]}, 1'b0);
            wr(OFS_FRONTEND, {16'h0, k[1:0], 1'b1, 13'h0}, 1'b0);
            half = 0;
            want_ch = 2'h0;
            for (int c = 2; c >= 0; c--)
                if (v[c]) begin
                    half++;
                    if (v[2:0] >> (c + 1) == 0 || half == 1) want_ch = 2'h0;
                end
            half = 0;
            for (int c = 0; c < 3; c++)
                if (v[c]) begin
                    if (half == k)
                        want_ch = c[1:0];
                    half++;
                end
            check("limit valid", limit_sensor_valid, half > k);
            if (half > k)
                check("limit chan", limit_channel, want_ch);
        end
        $display("test limit select done");
        tally_and_finish();
    end
endmodule
